//--- design/fp_addsub.sv
// floating add/subtract datapath: sign selection, alignment, test, normalize
// assumes an APB master on clk; operands sit in an internal accumulator file
// Operation
// - exponents in accumulator/source register, fractions in dest and source/result registers
// - mode zero takes source from accumulator, else memory operand shifted left one
// - add with like or subtract with unlike signs adds magnitudes, otherwise subtracts
// - add with like signs keeps destination sign as result sign
// - subtract with unlike signs adds magnitudes, result takes destination sign
// - add with unlike signs: negative difference loads source sign
// - subtract with like signs: larger source gives inverted source sign
// - only destination minus source is computed; sign logic fixes the rest
// - fraction arithmetic uses magnitudes only, signs handled apart
// - smaller fraction shifts right by exponent difference
// - shift beyond 25 single or 57 double skips alignment, larger operand wins
// - every nonzero result normalized with bit 59 clear and bit 58 set
// - after effective add normalize directly, no sign or zero test
// - unaligned subtract result tested for sign; negative is nonzero
// - non-negative unaligned result decremented; sign change means zero
// - normalization rounds, or truncates when truncate bit set
// - normalization updates negative, zero, overflow and carry codes
// - status bit 5 selects truncate mode
// - status bit 7 selects double precision and its alignment limit
// - rounding adds one at bit 34 single or bit 2 double
// - result exponent is the larger operand exponent before normalization
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
module fp_addsub (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int FW = fp_addsub_pkg::FRAC_W;

  logic [1:0] rst_sync;
  logic sys_rst_n;
  fp_addsub_pkg::state_e state;
  fp_addsub_pkg::op_ctrl_s op;
  logic [7:0] fps;
  logic [3:0] cond_codes;
  logic [2:0] acc_index;
  logic [31:0] acc_hi_stage;
  logic [63:0] mem_opnd;
  logic signed [9:0] exponent_accumulator;
  logic signed [9:0] source_exponent_reg;
  logic signed [9:0] dest_exponent_scratch;
  logic [FW-1:0] dest_fraction_reg;
  logic [FW-1:0] src_result_fraction_reg;
  logic scratch_sign_reg;
  logic dest_sign_bit;
  logic entry_dest_sign;
  logic eff_sub;
  logic aligned;
  logic src_larger;
  logic zero_res;
  logic mem_we;
  logic [2:0] mem_waddr;
  logic [63:0] mem_wdata;
  logic [2:0] mem_raddr;
  logic [63:0] mem_rdata;
  logic apb_setup;
  logic apb_wr;
  logic busy;
  logic truncate_mode_bit;
  logic double_precision_bit;
  logic [9:0] diff_mag;
  logic [9:0] align_limit;
  logic [FW-1:0] keep_mask;
  logic [FW-1:0] round_one;
  logic [FW-1:0] round_sum;
  logic [FW-1:0] dec_val;
  logic sign_if_src_larger;
  fp_addsub_pkg::fp_word_s src_word;
  fp_addsub_pkg::fp_word_s result_word;
  logic exp_ovf;
  logic exp_unf;

  function automatic logic [FW-1:0] unpack(input fp_addsub_pkg::fp_word_s w);
    unpack = (w.exp == 8'h00) ? '0 : {2'h1, w.frac, 3'h0};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == fp_addsub_pkg::CTRL_OFS) || (a == fp_addsub_pkg::FPS_OFS) ||
                (a == fp_addsub_pkg::ACC_INDEX_OFS) || (a == fp_addsub_pkg::ACC_LO_OFS) ||
                (a == fp_addsub_pkg::ACC_HI_OFS) || (a == fp_addsub_pkg::MOPND_LO_OFS) ||
                (a == fp_addsub_pkg::MOPND_HI_OFS);
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign sys_rst_n = rst_sync[1];

  assign busy = (state != fp_addsub_pkg::ST_IDLE);
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;
  assign truncate_mode_bit = fps[fp_addsub_pkg::FPS_TRUNC_BIT];
  assign double_precision_bit = fps[fp_addsub_pkg::FPS_DOUBLE_BIT];
  assign diff_mag = dest_exponent_scratch[9] ? 10'(-dest_exponent_scratch) :
                    10'(dest_exponent_scratch);
  assign align_limit = double_precision_bit ? fp_addsub_pkg::DBL_ALIGN_MAX :
                       fp_addsub_pkg::SGL_ALIGN_MAX;
  assign keep_mask = double_precision_bit ? ({FW{1'b1}} << fp_addsub_pkg::DBL_ROUND_BIT + 1) :
                     ({FW{1'b1}} << fp_addsub_pkg::SGL_ROUND_BIT + 1);
  assign round_one = double_precision_bit ? (FW'(1) << fp_addsub_pkg::DBL_ROUND_BIT) :
                     (FW'(1) << fp_addsub_pkg::SGL_ROUND_BIT);
  assign round_sum = src_result_fraction_reg + round_one;
  assign dec_val = src_result_fraction_reg - FW'(1);
  assign sign_if_src_larger = op.sub_instr ? !scratch_sign_reg : scratch_sign_reg;
  assign src_word = op.mode_zero ? mem_rdata : mem_opnd;
  assign exp_ovf = exponent_accumulator > fp_addsub_pkg::EXP_MAX;
  assign exp_unf = exponent_accumulator < 10'sh001;
  assign result_word = {dest_sign_bit, exponent_accumulator[7:0],
                        src_result_fraction_reg[57:3]};

  // accumulator file port sharing: engine while busy, software while idle
  always_comb
  begin
    mem_raddr = acc_index;
    if (state == fp_addsub_pkg::ST_RD_DST)
    begin
      mem_raddr = op.dst_ac;
    end
    else if (state == fp_addsub_pkg::ST_RD_SRC)
    begin
      mem_raddr = op.src_ac;
    end
    mem_we = 1'b0;
    mem_waddr = acc_index;
    mem_wdata = {acc_hi_stage, pwdata};
    if (state == fp_addsub_pkg::ST_WRITE)
    begin
      mem_we = 1'b1;
      mem_waddr = op.dst_ac;
      mem_wdata = (zero_res || exp_unf) ? 64'h0 : result_word;
    end
    else if (apb_wr && paddr == fp_addsub_pkg::ACC_LO_OFS)
    begin
      mem_we = 1'b1;
    end
  end

  acc_file #(
    .DEPTH(8),
    .WIDTH(fp_addsub_pkg::WORD_W),
    .AW(fp_addsub_pkg::AC_AW)
  ) u_acc (
    .clk(clk),
    .rst_n(sys_rst_n),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // apb answer: ready in access phase, error on unmapped or write while busy
  always_ff @(posedge clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup && (!is_mapped(paddr) || (pwrite && busy));
      if (apb_setup && !pwrite)
      begin
        case (paddr)
          fp_addsub_pkg::CTRL_OFS: prdata <= {busy, 20'h0, op.src_ac, 1'b0, op.dst_ac,
                                              1'b0, op.mode_zero, op.sub_instr, 1'b0};
          fp_addsub_pkg::FPS_OFS: prdata <= {24'h0, fps[7:4], cond_codes};
          fp_addsub_pkg::ACC_INDEX_OFS: prdata <= {29'h0, acc_index};
          fp_addsub_pkg::ACC_LO_OFS: prdata <= mem_rdata[31:0];
          fp_addsub_pkg::ACC_HI_OFS: prdata <= mem_rdata[63:32];
          fp_addsub_pkg::MOPND_LO_OFS: prdata <= mem_opnd[31:0];
          fp_addsub_pkg::MOPND_HI_OFS: prdata <= mem_opnd[63:32];
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // software-written configuration
  always_ff @(posedge clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      fps <= fp_addsub_pkg::FPS_RESET;
      acc_index <= 3'h0;
      acc_hi_stage <= 32'h0;
      mem_opnd <= 64'h0;
      op <= '0;
    end
    else if (apb_wr)
    begin
      case (paddr)
        fp_addsub_pkg::CTRL_OFS: op <= {pwdata[10:8], pwdata[6:4], pwdata[2:1]};
        fp_addsub_pkg::FPS_OFS: fps <= pwdata[7:0] & 8'ha0;
        fp_addsub_pkg::ACC_INDEX_OFS: acc_index <= pwdata[2:0];
        fp_addsub_pkg::ACC_HI_OFS: acc_hi_stage <= pwdata;
        fp_addsub_pkg::MOPND_LO_OFS: mem_opnd[31:0] <= pwdata;
        fp_addsub_pkg::MOPND_HI_OFS: mem_opnd[63:32] <= pwdata;
        default: acc_index <= acc_index;
      endcase
    end
  end

  // sequencer
  always_ff @(posedge clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      state <= fp_addsub_pkg::ST_IDLE;
    end
    else
    begin
      case (state)
        fp_addsub_pkg::ST_IDLE:
          if (apb_wr && paddr == fp_addsub_pkg::CTRL_OFS && pwdata[0])
            state <= fp_addsub_pkg::ST_RD_DST;
        fp_addsub_pkg::ST_RD_DST: state <= fp_addsub_pkg::ST_RD_SRC;
        fp_addsub_pkg::ST_RD_SRC: state <= fp_addsub_pkg::ST_LOAD;
        fp_addsub_pkg::ST_LOAD: state <= fp_addsub_pkg::ST_ALIGN;
        fp_addsub_pkg::ST_ALIGN:
          state <= (diff_mag > align_limit) ? fp_addsub_pkg::ST_NORM :
                   fp_addsub_pkg::ST_ARITH;
        fp_addsub_pkg::ST_ARITH:
          state <= eff_sub ? fp_addsub_pkg::ST_TEST : fp_addsub_pkg::ST_NORM;
        fp_addsub_pkg::ST_TEST:
          state <= (!src_result_fraction_reg[59] && !aligned && dec_val[59]) ?
                   fp_addsub_pkg::ST_WRITE : fp_addsub_pkg::ST_NORM;
        fp_addsub_pkg::ST_NORM:
          if (src_result_fraction_reg == '0)
            state <= fp_addsub_pkg::ST_WRITE;
          else if (src_result_fraction_reg[59:58] == 2'h1)
            state <= fp_addsub_pkg::ST_ROUND;
        fp_addsub_pkg::ST_ROUND: state <= fp_addsub_pkg::ST_WRITE;
        fp_addsub_pkg::ST_WRITE: state <= fp_addsub_pkg::ST_IDLE;
        default: state <= fp_addsub_pkg::ST_IDLE;
      endcase
    end
  end

  // operand and result datapath
  always_ff @(posedge clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      exponent_accumulator <= 10'sh000;
      source_exponent_reg <= 10'sh000;
      dest_exponent_scratch <= 10'sh000;
      dest_fraction_reg <= '0;
      src_result_fraction_reg <= '0;
      scratch_sign_reg <= 1'b0;
      dest_sign_bit <= 1'b0;
      entry_dest_sign <= 1'b0;
      eff_sub <= 1'b0;
      aligned <= 1'b0;
      src_larger <= 1'b0;
      zero_res <= 1'b0;
    end
    else
    begin
      case (state)
        fp_addsub_pkg::ST_IDLE:
          zero_res <= 1'b0;
        fp_addsub_pkg::ST_RD_SRC:
        begin
          dest_sign_bit <= mem_rdata[63];
          entry_dest_sign <= mem_rdata[63];
          exponent_accumulator <= {2'h0, mem_rdata[62:55]};
          dest_fraction_reg <= unpack(mem_rdata);
        end
        fp_addsub_pkg::ST_LOAD:
        begin
          scratch_sign_reg <= src_word.sign;
          source_exponent_reg <= {2'h0, src_word.exp};
          dest_exponent_scratch <= exponent_accumulator - {2'h0, src_word.exp};
          if (op.mode_zero)
            src_result_fraction_reg <= unpack(src_word);
          else
            src_result_fraction_reg <= (src_word.exp == 8'h00) ? '0 :
                                       ({3'h1, src_word.frac, 2'h0} << 1);
          eff_sub <= op.sub_instr ^ (src_word.sign ^ dest_sign_bit);
        end
        fp_addsub_pkg::ST_ALIGN:
        begin
          src_larger <= dest_exponent_scratch[9];
          aligned <= (diff_mag != 10'h000);
          if (dest_exponent_scratch[9])
          begin
            exponent_accumulator <= source_exponent_reg;
            if (diff_mag > align_limit)
            begin
              dest_sign_bit <= sign_if_src_larger;
            end
            else
            begin
              dest_fraction_reg <= dest_fraction_reg >> diff_mag;
            end
          end
          else if (diff_mag > align_limit)
          begin
            src_result_fraction_reg <= dest_fraction_reg;
          end
          else
          begin
            src_result_fraction_reg <= src_result_fraction_reg >> diff_mag;
          end
        end
        fp_addsub_pkg::ST_ARITH:
          // magnitudes only; the sign bits never enter the sum
          src_result_fraction_reg <= eff_sub ?
                                     dest_fraction_reg - src_result_fraction_reg :
                                     dest_fraction_reg + src_result_fraction_reg;
        fp_addsub_pkg::ST_TEST:
          if (src_result_fraction_reg[59])
          begin
            src_result_fraction_reg <= ~src_result_fraction_reg + FW'(1);
            dest_sign_bit <= sign_if_src_larger;
            src_larger <= 1'b1;
          end
          else if (!aligned && dec_val[59])
          begin
            zero_res <= 1'b1;
          end
        fp_addsub_pkg::ST_NORM:
          if (src_result_fraction_reg == '0)
          begin
            zero_res <= 1'b1;
          end
          else if (src_result_fraction_reg[59])
          begin
            src_result_fraction_reg <= src_result_fraction_reg >> 1;
            exponent_accumulator <= exponent_accumulator + 10'sh001;
          end
          else if (!src_result_fraction_reg[58])
          begin
            src_result_fraction_reg <= src_result_fraction_reg << 1;
            exponent_accumulator <= exponent_accumulator - 10'sh001;
          end
        fp_addsub_pkg::ST_ROUND:
          if (truncate_mode_bit)
          begin
            src_result_fraction_reg <= src_result_fraction_reg & keep_mask;
          end
          else if (round_sum[59])
          begin
            src_result_fraction_reg <= (round_sum >> 1) & keep_mask;
            exponent_accumulator <= exponent_accumulator + 10'sh001;
          end
          else
          begin
            src_result_fraction_reg <= round_sum & keep_mask;
          end
        default: zero_res <= zero_res;
      endcase
    end
  end

  // floating condition codes: n z v c
  always_ff @(posedge clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      cond_codes <= 4'h0;
    end
    else if (state == fp_addsub_pkg::ST_WRITE)
    begin
      cond_codes <= {dest_sign_bit && !(zero_res || exp_unf), zero_res || exp_unf,
                     exp_ovf && !zero_res, 1'b0};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!sys_rst_n);

  op_select_a: assert property (state == fp_addsub_pkg::ST_ARITH && !eff_sub |=>
    src_result_fraction_reg == $past(dest_fraction_reg) + $past(src_result_fraction_reg))
    else $error("effective add did not add magnitudes");
  sub_order_a: assert property (state == fp_addsub_pkg::ST_ARITH && eff_sub |=>
    src_result_fraction_reg == $past(dest_fraction_reg) - $past(src_result_fraction_reg))
    else $error("effective subtract not dest minus source");
  add_sign_a: assert property (state == fp_addsub_pkg::ST_WRITE && !eff_sub
    |-> dest_sign_bit == entry_dest_sign)
    else $error("effective add changed destination sign");
  sub_sign_a: assert property (state == fp_addsub_pkg::ST_WRITE && eff_sub
    |-> dest_sign_bit == (src_larger ? (op.sub_instr ^ !scratch_sign_reg) ^ 1'b1 :
                                       entry_dest_sign))
    else $error("effective subtract sign wrong");
  align_shift_a: assert property (state == fp_addsub_pkg::ST_ALIGN &&
    !dest_exponent_scratch[9] && diff_mag <= align_limit |=>
    src_result_fraction_reg == ($past(src_result_fraction_reg) >> $past(diff_mag)))
    else $error("source fraction not shifted by exponent difference");
  align_skip_a: assert property (state == fp_addsub_pkg::ST_ALIGN &&
    !dest_exponent_scratch[9] && diff_mag > align_limit |=>
    src_result_fraction_reg == $past(dest_fraction_reg) && state == fp_addsub_pkg::ST_NORM)
    else $error("out of range alignment not skipped");
  larger_exp_a: assert property (state == fp_addsub_pkg::ST_ALIGN |=>
    exponent_accumulator == ($past(dest_exponent_scratch[9]) ? $past(source_exponent_reg) :
                             $past(exponent_accumulator)))
    else $error("result exponent is not the larger one");
  norm_form_a: assert property (state == fp_addsub_pkg::ST_WRITE && !zero_res
    && exponent_accumulator > 10'sh000 |-> src_result_fraction_reg[59:58] == 2'h1)
    else $error("stored fraction not normalized");
  zero_store_a: assert property (state == fp_addsub_pkg::ST_TEST && !aligned &&
    src_result_fraction_reg == '0 |=> state == fp_addsub_pkg::ST_WRITE ##1 cond_codes[2])
    else $error("zero difference not detected");
  trunc_mask_a: assert property (state == fp_addsub_pkg::ST_ROUND && truncate_mode_bit
    |=> src_result_fraction_reg == ($past(src_result_fraction_reg) & $past(keep_mask)))
    else $error("truncate mode altered kept bits");

  add_path_c: cover property (state == fp_addsub_pkg::ST_ARITH && !eff_sub);
  neg_diff_c: cover property (state == fp_addsub_pkg::ST_TEST && src_result_fraction_reg[59]);
  skip_c: cover property (state == fp_addsub_pkg::ST_ALIGN && diff_mag > align_limit);
  round_carry_c: cover property (state == fp_addsub_pkg::ST_ROUND && !truncate_mode_bit &&
    round_sum[59]);

endmodule

//--- design/fp_addsub_pkg.sv
// constants, layouts and state types for the floating add/subtract datapath
// assumes a single 100 MHz clock domain and an APB register port
package fp_addsub_pkg;

  // internal fraction: bit 59 guard/sign, bit 58 leading one
  localparam int FRAC_W = 60;
  localparam int EXP_W = 10;
  localparam int WORD_W = 64;
  localparam int AC_AW = 3;
  localparam int NORM_SIGN_BIT = 59;
  localparam int NORM_LEAD_BIT = 58;

  // alignment limits and rounding positions
  localparam logic [9:0] SGL_ALIGN_MAX = 10'h019;
  localparam logic [9:0] DBL_ALIGN_MAX = 10'h039;
  localparam int SGL_ROUND_BIT = 34;
  localparam int DBL_ROUND_BIT = 2;
  localparam logic signed [9:0] EXP_MAX = 10'sh0ff;

  // status register bit positions
  localparam int FPS_TRUNC_BIT = 5;
  localparam int FPS_DOUBLE_BIT = 7;
  localparam logic [7:0] FPS_RESET = 8'h00;

  // control register bit positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SUB_BIT = 1;
  localparam int CTRL_MODE0_BIT = 2;
  localparam int CTRL_DST_LSB = 4;
  localparam int CTRL_SRC_LSB = 8;
  localparam int CTRL_BUSY_BIT = 31;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FPS_OFS = 8'h04;
  localparam logic [7:0] ACC_INDEX_OFS = 8'h08;
  localparam logic [7:0] ACC_LO_OFS = 8'h0c;
  localparam logic [7:0] ACC_HI_OFS = 8'h10;
  localparam logic [7:0] MOPND_LO_OFS = 8'h14;
  localparam logic [7:0] MOPND_HI_OFS = 8'h18;

  // stored word: sign, biased exponent, fraction without hidden bit
  typedef struct packed {
    logic sign;
    logic [7:0] exp;
    logic [54:0] frac;
  } fp_word_s;

  typedef struct packed {
    logic [2:0] src_ac;
    logic [2:0] dst_ac;
    logic mode_zero;
    logic sub_instr;
  } op_ctrl_s;

  typedef enum {
    ST_IDLE, ST_RD_DST, ST_RD_SRC, ST_LOAD, ST_ALIGN, ST_ARITH, ST_TEST,
    ST_NORM, ST_ROUND, ST_WRITE
  } state_e;

endpackage

//--- design/acc_file.sv
// accumulator file: one write port, one read port with registered data
// assumes one clock; the owner keeps reads and writes of a word apart
`timescale 1ns/100ps
module acc_file #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 64,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end

endmodule

//--- verification/apb_host.sv
// apb master model standing in for the host that loads operands and starts work
// assumes the bench clock; requests change only just after a rising edge
`timescale 1ns/100ps
module apb_host (
  // clock
  input wire logic clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // idle address and data lines are inverted so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

//--- verification/float_add_sub_sign_align_tb.sv
// self-checking bench for the floating add/subtract datapath
// assumes apb_host as register master and the design package constants
`timescale 1ns/100ps
module float_add_sub_sign_align_tb;
  logic clk;
  logic rst_n;
  logic psel, penable, pwrite, pready, pslverr, ev, sg;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, lfsr;
  logic [63:0] dw, sw, got;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  localparam logic [7:0] E0 = 8'h40;
  localparam logic [54:0] F15 = 55'h40000000000000;

  fp_addsub DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  apb_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // result sign: like-sign add keeps dest, unlike subtract keeps dest, else larger wins
  function automatic logic exp_sign(input logic sub, input logic ss, input logic sd,
      input logic dbig);
    if (!(sub ^ ss ^ sd) || dbig)
      return sd;
    return ss ^ sub;
  endfunction

  task automatic final_report();
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rv, ev);
  endtask

  task automatic put_acc(input logic [2:0] i, input logic [63:0] w);
    wr(fp_addsub_pkg::ACC_INDEX_OFS, {29'h0, i});
    wr(fp_addsub_pkg::ACC_HI_OFS, w[63:32]);
    wr(fp_addsub_pkg::ACC_LO_OFS, w[31:0]);
  endtask

  task automatic get_acc(input logic [2:0] i);
    wr(fp_addsub_pkg::ACC_INDEX_OFS, {29'h0, i});
    host.xfer(1'b0, fp_addsub_pkg::ACC_LO_OFS, 32'h0, rv, ev);
    got[31:0] = rv;
    host.xfer(1'b0, fp_addsub_pkg::ACC_HI_OFS, 32'h0, rv, ev);
    got[63:32] = rv;
  endtask

  // start, optionally try a refused write while busy, then poll busy under a bound
  task automatic run_op(input logic [2:0] d, input logic [2:0] s, input logic sub,
      input logic m0, input logic probe);
    int n;
    wr(fp_addsub_pkg::CTRL_OFS, {21'h0, s, 1'b0, d, 1'b0, m0, sub, 1'b1});
    if (probe)
    begin
      host.xfer(1'b1, fp_addsub_pkg::FPS_OFS, 32'h0, rv, ev);
      chk({63'h0, ev}, 64'h1);
    end
    n = 0;
    rv = 32'h80000000;
    while (rv[31] !== 1'b0 && n < 200)
    begin
      host.xfer(1'b0, fp_addsub_pkg::CTRL_OFS, 32'h0, rv, ev);
      n++;
    end
    chk({63'h0, rv[31]}, 64'h0);
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      num_errors++;
      final_report();
    end
  end

  logic [7:0] fps [6] = '{8'h00, 8'h20, 8'h00, 8'h80, 8'ha0, 8'h80};
  logic [7:0] dif [6] = '{8'h18, 8'h18, 8'h1a, 8'h38, 8'h38, 8'h3a};
  logic [54:0] efr [6] = '{55'h100000000, 55'h0, 55'h0, 55'h1, 55'h0, 55'h0};

  initial
  begin
    logic [2:0] d;
    rst_n = 1'b0;
    lfsr = 32'h39af1b89;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    host.xfer(1'b0, fp_addsub_pkg::FPS_OFS, 32'h0, rv, ev);
    chk({32'h0, rv}, {56'h0, fp_addsub_pkg::FPS_RESET});
    host.xfer(1'b0, 8'h1c, 32'h0, rv, ev);
    chk({31'h0, ev, rv}, {31'h0, 1'b1, 32'h0});
    for (int k = 0; k < 16; k++)
    begin
      lfsr = next_rand(lfsr);
      d = lfsr[2:0];
      dw = {k[1], E0, k[0] ? F15 : 55'h0};
      sw = {k[2], E0, k[0] ? 55'h0 : F15};
      put_acc(d, dw);
      put_acc(d ^ 3'h4, lfsr[3] ? sw : ~sw);
      wr(fp_addsub_pkg::MOPND_HI_OFS, lfsr[3] ? ~sw[63:32] : sw[63:32]);
      wr(fp_addsub_pkg::MOPND_LO_OFS, lfsr[3] ? ~sw[31:0] : sw[31:0]);
      run_op(d, d ^ 3'h4, k[3], lfsr[3], k == 0);
      get_acc(d);
      sg = exp_sign(k[3], k[2], k[1], k[0]);
      if (k[3] ^ k[2] ^ k[1])
        chk(got, {sg, E0 - 8'h01, 55'h0});
      else
        chk(got, {sg, E0 + 8'h01, 55'h20000000000000});
      host.xfer(1'b0, fp_addsub_pkg::FPS_OFS, 32'h0, rv, ev);
      chk({60'h0, rv[3:0]}, {60'h0, sg, 3'b000});
    end
    put_acc(3'h0, {1'b1, E0, 55'h0});
    put_acc(3'h1, {1'b1, E0, 55'h0});
    run_op(3'h0, 3'h1, 1'b1, 1'b1, 1'b0);
    get_acc(3'h0);
    chk(got, 64'h0);
    host.xfer(1'b0, fp_addsub_pkg::FPS_OFS, 32'h0, rv, ev);
    chk({60'h0, rv[3:0]}, 64'h4);
    for (int j = 0; j < 6; j++)
    begin
      wr(fp_addsub_pkg::FPS_OFS, {24'h0, fps[j]});
      put_acc(3'h2, {1'b0, 8'h10 + dif[j], 55'h0});
      put_acc(3'h3, {1'b0, 8'h10, 55'h0});
      run_op(3'h2, 3'h3, 1'b0, 1'b1, 1'b0);
      get_acc(3'h2);
      chk(got, {1'b0, 8'h10 + dif[j], efr[j]});
    end
    // source far larger with unlike signs: alignment skipped, source sign and exponent win
    wr(fp_addsub_pkg::FPS_OFS, 32'h0);
    put_acc(3'h4, {1'b0, 8'h10, 55'h0});
    put_acc(3'h5, {1'b1, 8'h2a, 55'h0});
    run_op(3'h4, 3'h5, 1'b0, 1'b1, 1'b0);
    get_acc(3'h4);
    chk(got, {1'b1, 8'h2a, 55'h0});
    // exponent carried past its top value raises the overflow code
    put_acc(3'h6, {1'b0, 8'hff, 55'h0});
    run_op(3'h6, 3'h6, 1'b0, 1'b1, 1'b0);
    host.xfer(1'b0, fp_addsub_pkg::FPS_OFS, 32'h0, rv, ev);
    chk({60'h0, rv[3:0]}, 64'h2);
    final_report();
  end
endmodule
